// >>> logic/card_ctl_pkg.sv
// shared types and constants of the card host control block
package card_ctl_pkg;

	// clock and derived cycle counts
	localparam int unsigned CLK_PERIOD_NS = 40;
	localparam int unsigned INIT_TIME_US = 1000; // internal initialisation time
	localparam int unsigned INIT_CYCLES = (INIT_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned IRQ_PULSE_NS = 200; // pulse mode interrupt width
	localparam int unsigned IRQ_PULSE_CYCLES = (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned POR_SETTLE_CYCLES = 3; // lets the synchronisers fill

	// counter widths
	localparam int unsigned CNT_W = 20;
	localparam int unsigned PULSE_W = 4;

	// pin values after reset
	localparam logic PIN_HIGH = 1'h1;
	localparam logic PIN_LOW = 1'h0;

	// top level state, gray along por -> init -> run -> hold
	typedef enum logic [1:0] {
		ST_POR = 2'h0,
		ST_INIT = 2'h1,
		ST_RUN = 2'h3,
		ST_HOLD = 2'h2
	} card_state_t;

	// host interface personality
	typedef enum logic [1:0] {
		MODE_MEM = 2'h0,
		MODE_IO = 2'h1,
		MODE_IDE = 2'h2
	} card_mode_t;

	// host pins into the card
	typedef struct packed {
		logic card_reset;  // reset pin, polarity depends on mode
		logic ide_sel_n;   // low selects true ide mode
		logic attr_sel_n;  // low attribute, high common memory
		logic wr_n;        // write strobe
		logic dma_ack_n;   // dma acknowledge
	} host_in_t;

	// host pins out of the card
	typedef struct packed {
		logic ready_irq;   // ready, irq low or irq high by mode
		logic wait_n;      // wait / io ready
		logic wp_iois16;   // write protect or 16 bit indication
		logic vs1_n;       // voltage sense 1
		logic vs2_n;       // voltage sense 2 level
		logic vs2_oe;      // voltage sense 2 enable
	} host_out_t;

	// card core status into the block
	typedef struct packed {
		logic busy;        // core busy
		logic irq;         // core interrupt request
		logic irq_level;   // 1 level mode, 0 pulse mode
		logic io_mode;     // pc card i/o interface configured
		logic dma_en;      // dma mode enabled
		logic port16;      // addressed port is 16 bit capable
		logic word_xfer;   // core expects a word transfer
	} core_in_t;

	// events and levels to the card core
	typedef struct packed {
		logic card_rst;    // hold core in reset
		logic init_done;   // initialisation complete
		logic ide_mode;    // true ide mode latched
		logic attr_we;     // attribute memory write pulse
		logic common_we;   // common memory write pulse
		logic cfg_we;      // configuration register write pulse
		logic dma_ack;     // qualified dma acknowledge level
	} core_out_t;

	// all state of the top module
	typedef struct packed {
		card_state_t state;
		card_mode_t mode;
		logic pwr_hold;           // reset held since power-up
		logic [CNT_W-1:0] cnt;    // settle and init counter
		logic [PULSE_W-1:0] pulse; // irq pulse counter
		logic irq_q;              // irq request delayed
		logic wr_q;               // synced write strobe delayed
		host_out_t hout;
		core_out_t cout;
	} ctl_state_t;

	// pin levels after reset
	localparam host_out_t HOUT_RST = '{ready_irq: PIN_LOW, wait_n: PIN_HIGH, wp_iois16: PIN_HIGH,
		vs1_n: PIN_LOW, vs2_n: PIN_HIGH, vs2_oe: PIN_LOW};

	// saturating down count, used by the settle and init counter
	function automatic logic [CNT_W-1:0] dec_sat(input logic [CNT_W-1:0] v);
		dec_sat = (v == '0) ? '0 : v - CNT_W'(1);
	endfunction

endpackage

// >>> logic/pin_sync.sv
// two stage synchroniser for a group of host pins
`timescale 1ns/1ns
module pin_sync
	import card_ctl_pkg::*;
(
	// clock, reset, enable
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// pins
	input card_ctl_pkg::host_in_t pins_i,
	output card_ctl_pkg::host_in_t pins_o
);

	// both stages in one struct
	typedef struct packed {
		host_in_t meta;  // first stage, read only by second
		host_in_t stab;  // second stage
	} sync_state_t;

	// idle levels: reset released, pc card mode, strobes inactive
	localparam host_in_t PINS_IDLE = '{card_reset: 1'h0, ide_sel_n: 1'h1, attr_sel_n: 1'h1,
		wr_n: 1'h1, dma_ack_n: 1'h1};

	sync_state_t st_r;
	sync_state_t st_nxt;

	// shift pins through both stages
	always_comb begin
		st_nxt = st_r;
		st_nxt.meta = pins_i;
		st_nxt.stab = st_r.meta;
	end

	// register, frozen while enable low
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r <= '{meta: PINS_IDLE, stab: PINS_IDLE};
		end else if (ce_i) begin
			st_r <= st_nxt;
		end
	end

	assign pins_o = st_r.stab;

endmodule

// >>> logic/card_host_ctl.sv
// control and status pins of the card host interface
// Behaviour
// - memory mode ready low busy, high ready
// - ready low until initialisation completes
// - reset held since power-up keeps ready high
// - i/o mode irq pulsed or held low
// - ide mode interrupt is active high
// - select line picks common or attribute memory
// - dma acknowledge ignored while dma disabled
// - pc card modes reset active high
// - power-up reset with reset pin high, or with it low in ide mode
// - ide mode reset active low
// - wait / io ready never asserted
// - memory mode write strobe captures data
// - i/o mode write strobe writes configuration
// - write protect low after initialisation
// - i/o mode 16 bit port indication low
// - ide mode word transfer indication low
// - voltage sense 1 grounded, 2 reserved
`timescale 1ns/1ns
module card_host_ctl
	import card_ctl_pkg::*;
#(
	parameter int unsigned INIT_CYCLES_P = card_ctl_pkg::INIT_CYCLES // shorten in simulation
) (
	// clock, reset, enable
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// host pins
	input card_ctl_pkg::host_in_t host_i,
	output card_ctl_pkg::host_out_t host_o,
	// card core side
	input card_ctl_pkg::core_in_t core_i,
	output card_ctl_pkg::core_out_t core_o
);

	// synchronised host pins
	host_in_t host_s;

	// state register and its next value
	ctl_state_t st_r;
	ctl_state_t st_nxt;

	// combinational helpers
	logic rst_act;      // card reset seen in current mode
	logic wr_rise;      // end of a host write strobe
	logic irq_rise;     // new core interrupt request
	logic pulse_low;    // pulse mode irq active

	// host pins through two flops before use
	pin_sync u_sync (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.pins_i(host_i),
		.pins_o(host_s)
	);

	// next state of the whole block
	always_comb begin
		st_nxt = st_r;
		rst_act = 1'h0;
		wr_rise = 1'h0;
		irq_rise = 1'h0;
		pulse_low = 1'h0;

		// reset pin polarity follows the latched mode
		if (st_r.mode == MODE_IDE) begin
			rst_act = !host_s.card_reset;
		end else begin
			rst_act = host_s.card_reset;
		end

		// edge detection on synced strobe and core request
		wr_rise = !st_r.wr_q && host_s.wr_n;
		irq_rise = core_i.irq && !st_r.irq_q;
		st_nxt.wr_q = host_s.wr_n;
		st_nxt.irq_q = core_i.irq;

		// sequencing
		unique case (st_r.state)
			// wait for synchronisers, then catch mode and reset strap
			ST_POR: begin
				st_nxt.cnt = dec_sat(st_r.cnt);
				if (st_r.cnt == '0) begin
					st_nxt.mode = host_s.ide_sel_n ? MODE_MEM : MODE_IDE;
					if ((host_s.ide_sel_n && host_s.card_reset) || (!host_s.ide_sel_n && !host_s.card_reset)) begin
						st_nxt.state = ST_HOLD;
						st_nxt.pwr_hold = 1'h1;
					end else begin
						st_nxt.state = ST_INIT;
						st_nxt.cnt = CNT_W'(INIT_CYCLES_P);
					end
				end
			end
			// internal initialisation running
			ST_INIT: begin
				st_nxt.cnt = dec_sat(st_r.cnt);
				if (rst_act) begin
					st_nxt.state = ST_HOLD;
				end else if (st_r.cnt == '0) begin
					st_nxt.state = ST_RUN;
				end
			end
			// normal operation
			ST_RUN: begin
				if (rst_act) begin
					st_nxt.state = ST_HOLD;
				end
			end
			// reset held by the host
			ST_HOLD: begin
				if (!rst_act) begin
					st_nxt.state = ST_INIT;
					st_nxt.pwr_hold = 1'h0;
					st_nxt.cnt = CNT_W'(INIT_CYCLES_P);
				end
			end
		endcase

		// pc card personality follows core configuration in pc card modes
		if (st_r.mode != MODE_IDE && st_r.state != ST_POR) begin
			st_nxt.mode = core_i.io_mode ? MODE_IO : MODE_MEM;
		end

		// pulse mode interrupt stretcher, retriggered by new requests
		if (st_nxt.state == ST_RUN && irq_rise && !core_i.irq_level) begin
			st_nxt.pulse = PULSE_W'(IRQ_PULSE_CYCLES);
		end else if (st_r.pulse != '0) begin
			st_nxt.pulse = st_r.pulse - PULSE_W'(1);
		end
		pulse_low = (st_nxt.pulse != '0);

		// shared pin 37 by personality
		unique case (st_nxt.mode)
			// ready/busy, or high while reset held since power-up
			MODE_MEM: begin
				st_nxt.hout.ready_irq = (st_nxt.state == ST_RUN && !core_i.busy)
					|| (st_nxt.state == ST_HOLD && st_nxt.pwr_hold);
			end
			// active low interrupt, level or pulse
			MODE_IO: begin
				if (st_nxt.state != ST_RUN) begin
					st_nxt.hout.ready_irq = PIN_HIGH;
				end else if (core_i.irq_level) begin
					st_nxt.hout.ready_irq = !core_i.irq;
				end else begin
					st_nxt.hout.ready_irq = !pulse_low;
				end
			end
			// active high interrupt
			MODE_IDE: begin
				st_nxt.hout.ready_irq = (st_nxt.state == ST_RUN) && core_i.irq;
			end
			default: begin
				st_nxt.hout.ready_irq = PIN_LOW;
			end
		endcase

		// shared pin 24 by personality
		unique case (st_nxt.mode)
			// no switch, low once initialised
			MODE_MEM: begin
				st_nxt.hout.wp_iois16 = (st_nxt.state != ST_RUN);
			end
			// 16 bit or odd byte port
			MODE_IO: begin
				st_nxt.hout.wp_iois16 = !(st_nxt.state == ST_RUN && core_i.port16);
			end
			// word transfer expected
			MODE_IDE: begin
				st_nxt.hout.wp_iois16 = !(st_nxt.state == ST_RUN && core_i.word_xfer);
			end
			default: begin
				st_nxt.hout.wp_iois16 = PIN_HIGH;
			end
		endcase

		// static pins
		st_nxt.hout.wait_n = PIN_HIGH;
		st_nxt.hout.vs1_n = PIN_LOW;
		st_nxt.hout.vs2_n = PIN_HIGH;
		st_nxt.hout.vs2_oe = PIN_LOW;

		// levels to the core
		st_nxt.cout.card_rst = (st_nxt.state == ST_HOLD) || (st_nxt.state == ST_POR);
		st_nxt.cout.init_done = (st_nxt.state == ST_RUN);
		st_nxt.cout.ide_mode = (st_nxt.mode == MODE_IDE);

		// write strobe decode, accepted only in run
		st_nxt.cout.attr_we = 1'h0;
		st_nxt.cout.common_we = 1'h0;
		st_nxt.cout.cfg_we = 1'h0;
		if (wr_rise && st_r.state == ST_RUN) begin
			unique case (st_r.mode)
				// common when select high, attribute when low
				MODE_MEM: begin
					st_nxt.cout.common_we = host_s.attr_sel_n;
					st_nxt.cout.attr_we = !host_s.attr_sel_n;
				end
				// configuration registers sit in attribute space
				MODE_IO: begin
					st_nxt.cout.cfg_we = !host_s.attr_sel_n;
				end
				// strobe not used
				MODE_IDE: begin
					st_nxt.cout.cfg_we = 1'h0;
				end
				default: begin
					st_nxt.cout.cfg_we = 1'h0;
				end
			endcase
		end

		// dma acknowledge only counts with dma enabled in ide mode
		st_nxt.cout.dma_ack = core_i.dma_en && (st_nxt.mode == MODE_IDE)
			&& (st_nxt.state == ST_RUN) && !host_s.dma_ack_n;
	end

	// register all state, frozen while enable low
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r.state <= ST_POR;
			st_r.mode <= MODE_MEM;
			st_r.pwr_hold <= 1'h0;
			st_r.cnt <= CNT_W'(POR_SETTLE_CYCLES);
			st_r.pulse <= '0;
			st_r.irq_q <= 1'h0;
			st_r.wr_q <= 1'h1;
			st_r.hout <= HOUT_RST;
			st_r.cout <= '{card_rst: 1'h1, default: 1'h0};
		end else if (ce_i) begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from flops
	assign host_o = st_r.hout;
	assign core_o = st_r.cout;

	// checks
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i || !ce_i);

	wait_never_a: assert property (host_o.wait_n)
		else $error("wait pin asserted");
	volt_sense_a: assert property (!host_o.vs1_n && !host_o.vs2_oe)
		else $error("voltage sense pins wrong");
	init_ready_low_a: assert property ((st_r.state == ST_INIT && st_r.mode == MODE_MEM) |-> !host_o.ready_irq)
		else $error("ready high during init");
	busy_ready_a: assert property ((st_r.state == ST_RUN && st_r.mode == MODE_MEM && $past(ce_i))
		|-> host_o.ready_irq == !$past(core_i.busy))
		else $error("ready does not follow busy");
	pwr_hold_ready_a: assert property ((st_r.state == ST_HOLD && st_r.pwr_hold && st_r.mode == MODE_MEM)
		|-> host_o.ready_irq)
		else $error("ready low with reset held since power-up");
	ide_intrq_a: assert property ((st_r.state == ST_RUN && st_r.mode == MODE_IDE && $past(ce_i))
		|-> host_o.ready_irq == $past(core_i.irq))
		else $error("ide interrupt level wrong");
	level_irq_a: assert property ((st_r.state == ST_RUN && st_r.mode == MODE_IO && $past(ce_i)
		&& $past(core_i.irq_level)) |-> host_o.ready_irq == !$past(core_i.irq))
		else $error("level interrupt wrong");
	pulse_width_a: assert property (($fell(host_o.ready_irq) && st_r.mode == MODE_IO && !$past(core_i.irq_level)
		&& st_r.state == ST_RUN) |-> (!host_o.ready_irq || st_r.state != ST_RUN || st_r.mode != MODE_IO)[*5])
		else $error("interrupt pulse too short");
	dma_ignored_a: assert property ((!$past(core_i.dma_en) && $past(ce_i)) |-> !core_o.dma_ack)
		else $error("acknowledge used with dma disabled");
	ide_wr_ignored_a: assert property ((st_r.mode == MODE_IDE && $past(st_r.mode) == MODE_IDE)
		|-> !(core_o.attr_we || core_o.common_we || core_o.cfg_we))
		else $error("write strobe used in ide mode");
	hold_reset_a: assert property ((st_r.state == ST_HOLD) |-> core_o.card_rst && !core_o.init_done)
		else $error("core not reset while reset held");
	wp_low_a: assert property ((st_r.state == ST_RUN && st_r.mode == MODE_MEM) |-> !host_o.wp_iois16)
		else $error("write protect high after init");

	reach_run_c: cover property (st_r.state == ST_INIT ##1 st_r.state == ST_RUN);
	irq_pulse_c: cover property ($fell(host_o.ready_irq) && st_r.mode == MODE_IO);
	dma_ack_c: cover property ($rose(core_o.dma_ack));
	common_we_c: cover property (core_o.common_we);

endmodule

// >>> testbench/host_model.sv
// host socket model that drives the card control pins
`timescale 1ns/1ns
module host_model
	import card_ctl_pkg::*;
(
	// mode and requested levels
	input wire logic ide_i,
	input card_ctl_pkg::host_in_t req_i,
	// pins to the card
	output card_ctl_pkg::host_in_t pins_o
);
	import card_ctl_pkg::*;
	// pass the requested levels, an ide host keeps the write strobe high
	always_comb begin
		pins_o = req_i;
		if (ide_i) begin
			pins_o.wr_n = 1'h1;
		end
	end
endmodule

// >>> testbench/card_host_ctl_tb_top.sv
// self-checking bench of the card host control block
`timescale 1ns/1ns
module card_host_ctl_tb_top;
	import card_ctl_pkg::*;
	localparam int unsigned INIT_P = 8; // short initialisation
	localparam int LO = INIT_P - 3; // fewest waits before run
	logic core_clk_i = 1'h0;
	logic rst_n_i = 1'h0;
	logic ide = 1'h0; // host in ide mode
	logic ce = 1'h1; // clock enable to the block
	// requested pin levels, acknowledge idle high while no dma is wanted
	host_in_t req = '{1'h0, 1'h1, 1'h1, 1'h1, 1'h1};
	host_in_t pins;
	host_out_t hout;
	core_in_t core = '0;
	core_out_t cout;
	int bad_count = 0;
	int compares = 0;

	// clock
	initial begin
		forever #20 core_clk_i = ~core_clk_i;
	end

	host_model host_u (.ide_i(ide), .req_i(req), .pins_o(pins));
	card_host_ctl #(.INIT_CYCLES_P(INIT_P)) dut_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
		.host_i(pins), .host_o(hout), .core_i(core), .core_o(cout));

	// one comparison
	task automatic chk(input string name, input logic [3:0] exp, input logic [3:0] got);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	// n falling edges
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk_i);
	endtask

	// pins fixed in every mode
	task automatic chk_fixed();
		chk("wait_n", 4'h1, hout.wait_n);
		chk("vs1_n", 4'h0, hout.vs1_n);
		chk("vs2_oe", 4'h0, hout.vs2_oe);
		chk("vs2_n", 4'h1, hout.vs2_n);
	endtask

	// power-up with strap levels on reset and mode pins
	task automatic boot(input logic rst_pin, input logic sel_n);
		rst_n_i = 1'h0;
		req.card_reset = rst_pin;
		req.ide_sel_n = sel_n;
		ide = ~sel_n;
		cyc(10);
		chk("rst ready", 4'h0, hout.ready_irq);
		chk("rst wp", 4'h1, hout.wp_iois16);
		chk_fixed();
		rst_n_i = 1'h1;
		cyc(6);
	endtask

	// bounded wait for the end of initialisation
	task automatic wait_run();
		int n;
		n = 0;
		while (cout.init_done !== 1'h1 && n < 40) begin
			cyc(1);
			n++;
		end
		chk("init span", 4'h1, 4'(n >= LO && n < 40));
		cyc(1);
	endtask

	// strobe the write pin, count attribute, common and config pulses
	task automatic wr_strobe(input logic attr_n, input logic [3:0] ea, input logic [3:0] ec, input logic [3:0] eg);
		logic [3:0] na;
		logic [3:0] nc;
		logic [3:0] ng;
		na = 4'h0;
		nc = 4'h0;
		ng = 4'h0;
		req.attr_sel_n = attr_n;
		req.wr_n = 1'h0;
		cyc(3);
		req.wr_n = 1'h1;
		repeat (6) begin
			cyc(1);
			na += cout.attr_we;
			nc += cout.common_we;
			ng += cout.cfg_we;
		end
		chk("attr_we", ea, na);
		chk("common_we", ec, nc);
		chk("cfg_we", eg, ng);
	endtask

	// memory mode boot, ready, writes
	task automatic t_mem();
		boot(1'h0, 1'h1);
		chk("init ready", 4'h0, hout.ready_irq);
		chk("init rst", 4'h0, cout.card_rst);
		chk("init wp", 4'h1, hout.wp_iois16);
		wait_run();
		chk("run ready", 4'h1, hout.ready_irq);
		chk("run wp", 4'h0, hout.wp_iois16);
		chk("mem ide", 4'h0, cout.ide_mode);
		core.busy = 1'h1;
		cyc(2);
		chk("busy ready", 4'h0, hout.ready_irq);
		core.busy = 1'h0;
		cyc(2);
		chk("idle ready", 4'h1, hout.ready_irq);
		// enable low freezes ready although the core turns busy
		ce = 1'h0;
		core.busy = 1'h1;
		cyc(3);
		chk("frozen ready", 4'h1, hout.ready_irq);
		core.busy = 1'h0;
		ce = 1'h1;
		cyc(2);
		wr_strobe(1'h1, 4'h0, 4'h1, 4'h0);
		wr_strobe(1'h0, 4'h1, 4'h0, 4'h0);
		chk_fixed();
	endtask

	// reset pin in run, writes refused while held
	task automatic t_reset();
		req.card_reset = 1'h1;
		cyc(4);
		chk("held rst", 4'h1, cout.card_rst);
		chk("held ready", 4'h0, hout.ready_irq);
		wr_strobe(1'h1, 4'h0, 4'h0, 4'h0);
		req.card_reset = 1'h0;
		cyc(4);
		chk("freed rst", 4'h0, cout.card_rst);
		wait_run();
		chk("again ready", 4'h1, hout.ready_irq);
	endtask

	// i/o mode interrupts, config writes, port width
	task automatic t_io();
		logic [3:0] lows;
		lows = 4'h0;
		core.io_mode = 1'h1;
		cyc(2);
		chk("irq idle", 4'h1, hout.ready_irq);
		core.irq_level = 1'h1;
		core.irq = 1'h1;
		cyc(2);
		chk("irq level", 4'h0, hout.ready_irq);
		core.irq = 1'h0;
		cyc(2);
		chk("irq drop", 4'h1, hout.ready_irq);
		core.irq_level = 1'h0;
		core.irq = 1'h1;
		repeat (10) begin
			cyc(1);
			lows += !hout.ready_irq;
		end
		chk("irq pulse", 4'(IRQ_PULSE_CYCLES), lows);
		core.irq = 1'h0;
		wr_strobe(1'h0, 4'h0, 4'h0, 4'h1);
		wr_strobe(1'h1, 4'h0, 4'h0, 4'h0);
		core.port16 = 1'h1;
		cyc(2);
		chk("iois16 on", 4'h0, hout.wp_iois16);
		core.port16 = 1'h0;
		cyc(2);
		chk("iois16 off", 4'h1, hout.wp_iois16);
		core.io_mode = 1'h0;
	endtask

	// power-up with reset held keeps ready high
	task automatic t_hold();
		boot(1'h1, 1'h1);
		cyc(4);
		chk("hold rst", 4'h1, cout.card_rst);
		chk("hold ready", 4'h1, hout.ready_irq);
		req.card_reset = 1'h0;
		wait_run();
		chk("hold run", 4'h1, hout.ready_irq);
	endtask

	// true ide mode
	task automatic t_ide();
		// ide power-up with reset held low stays in reset
		boot(1'h0, 1'h0);
		cyc(4);
		chk("ide strap rst", 4'h1, cout.card_rst);
		chk("ide strap irq", 4'h0, hout.ready_irq);
		boot(1'h1, 1'h0);
		wait_run();
		chk("ide mode", 4'h1, cout.ide_mode);
		chk("intrq idle", 4'h0, hout.ready_irq);
		core.irq = 1'h1;
		cyc(2);
		chk("intrq on", 4'h1, hout.ready_irq);
		core.irq = 1'h0;
		core.word_xfer = 1'h1;
		cyc(2);
		chk("iocs16 on", 4'h0, hout.wp_iois16);
		core.word_xfer = 1'h0;
		cyc(2);
		chk("iocs16 off", 4'h1, hout.wp_iois16);
		req.dma_ack_n = 1'h0;
		cyc(4);
		chk("ack no dma", 4'h0, cout.dma_ack);
		core.dma_en = 1'h1;
		cyc(2);
		chk("ack dma", 4'h1, cout.dma_ack);
		req.dma_ack_n = 1'h1;
		cyc(4);
		chk("ack gone", 4'h0, cout.dma_ack);
		req.card_reset = 1'h0;
		cyc(4);
		chk("ide rst", 4'h1, cout.card_rst);
		req.card_reset = 1'h1;
		cyc(4);
		chk("ide unrst", 4'h0, cout.card_rst);
		chk_fixed();
	endtask

	// verdict and end of run
	task automatic final_report();
		if (bad_count == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		t_mem();
		t_reset();
		t_io();
		t_hold();
		t_ide();
		final_report();
	end

	// watchdog, far beyond the few hundred cycles the tests take
	initial begin
		repeat (5000) @(posedge core_clk_i);
		bad_count++;
		final_report();
	end
endmodule
